// file: rtl/iirp_pkg.sv
// Package for the pin input register path: register map, field positions,
// reset values and the packed state types of both design modules.
// Assumes a 32-bit Avalon-MM slave with byte addresses and one aligned word per register.
package iirp_pkg;
	// Bus geometry
	localparam int ADDR_W = 4;
	localparam int DATA_W = 32;
	// Register byte offsets
	localparam logic [ADDR_W-1:0] CTRL_OFS = 4'h0;
	localparam logic [ADDR_W-1:0] STAT_OFS = 4'h4;
	// Control field positions
	localparam int CTRL_SEL_A = 0;
	localparam int CTRL_SEL_B = 1;
	localparam int CTRL_LATCH = 2;
	localparam int CTRL_INV_CLK = 3;
	localparam int CTRL_GATE_IN = 4;
	localparam int CTRL_GATE_OUT = 5;
	localparam int CTRL_PRESET = 6;
	localparam int CTRL_W = 7;
	// Control reset: direct paths, flip-flop, rising edge, gate on both, preset low
	localparam logic [CTRL_W-1:0] CTRL_RESET = 7'h30;
	// Status field positions
	localparam int STAT_Q = 0;
	localparam int STAT_PIN = 1;
	localparam int STAT_GATE = 2;
	// Bus answer for unmapped reads
	localparam logic [DATA_W-1:0] UNMAPPED_DATA = 32'h0000_0000;

	// State of one storage element
	typedef struct packed {
		logic last_lvl; // Active clock level seen last cycle
		logic q;        // Stored value
	} iirp_store_type;

	// State of the top module
	typedef struct packed {
		logic [CTRL_W-1:0] ctrl;  // Control register
		logic wait_n_ack;         // Waitrequest level
		logic [DATA_W-1:0] rdata; // Read data holding register
		logic path_a;             // First array path
		logic path_b;             // Second array path
		logic out_gate;           // Enable routed to output element
	} iirp_top_type;
endpackage : iirp_pkg

// file: rtl/iirp_store.sv
// Input storage element: flip-flop or latch on a sampled element clock.
// Assumes i_elem_clk and i_d are synchronous to i_clk; edges are found by sampling.
`timescale 1ns/1ps
module iirp_store (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_reset,
	// Configuration
	input wire logic i_latch_mode,
	input wire logic i_invert_clk,
	input wire logic i_preset,
	// Control
	input wire logic i_gsr,
	input wire logic i_elem_clk,
	input wire logic i_enable,
	input wire logic i_d,
	// Stored value
	output logic o_q
);
	iirp_pkg::iirp_store_type st_ff; // Registered state
	iirp_pkg::iirp_store_type nxt_st; // Next state
	logic act_lvl; // Element clock after polarity choice
	logic act_edge; // Active edge this cycle

	// Polarity choice gives the inverted variants
	assign act_lvl = i_elem_clk ^ i_invert_clk;
	assign act_edge = act_lvl & ~st_ff.last_lvl;
	assign o_q = st_ff.q;

	// Next state of the element
	always_comb begin
		nxt_st = st_ff;
		nxt_st.last_lvl = act_lvl;
		if (i_reset || i_gsr) begin
			// Power-up or global set/reset wins over everything
			nxt_st.q = i_preset;
			nxt_st.last_lvl = 1'b0;
		end else if (!i_enable) begin
			// Gate low holds in both forms
			nxt_st.q = st_ff.q;
		end else if (i_latch_mode) begin
			// Transparent while the active level stands
			if (act_lvl) begin
				nxt_st.q = i_d;
			end
		end else if (act_edge) begin
			// Capture only on the active edge
			nxt_st.q = i_d;
		end else begin
			// Level without edge keeps the value
			nxt_st.q = st_ff.q;
		end
	end

	// State register
	always_ff @(posedge i_clk) begin
		st_ff <= nxt_st;
	end

	// Preset is loaded on set/reset
	gsr_load_a: assert property (@(posedge i_clk) disable iff (i_reset)
		i_gsr |=> (o_q == $past(i_preset))) else $error("preset not loaded");
	// Flip-flop captures on active edge
	ff_capture_a: assert property (@(posedge i_clk) disable iff (i_reset)
		(!i_gsr && !i_latch_mode && i_enable && act_edge) |=> (o_q == $past(i_d)))
		else $error("flop missed edge capture");
	// Flip-flop holds without edge
	ff_noedge_a: assert property (@(posedge i_clk) disable iff (i_reset)
		(!i_gsr && !i_latch_mode && !act_edge) |=> $stable(o_q)) else $error("flop changed without edge");
	// Latch follows data while open
	latch_open_a: assert property (@(posedge i_clk) disable iff (i_reset)
		(!i_gsr && i_latch_mode && i_enable && act_lvl) |=> (o_q == $past(i_d)))
		else $error("latch not transparent");
	// Disabled element holds
	gate_hold_a: assert property (@(posedge i_clk) disable iff (i_reset)
		(!i_gsr && !i_enable) |=> $stable(o_q)) else $error("element moved while gated off");
endmodule : iirp_store

// file: rtl/iirp_top.sv
// Pin input register path with Avalon-MM control and status registers.
// Assumes pin, element clock, gate and set/reset inputs are synchronous to i_clk.
//
// Notes on behaviour
// - Two array paths, each direct or stored
// - Storage element is flip-flop or latch
// - Flip-flop captures pin on rising edge
// - Latch transparent while clock high, else holds
// - Clock polarity selectable for both forms
// - One gate, routed to input, output, both
// - Gate polarity fixed active high
// - Gate low holds element in both forms
// - Power-up or set/reset loads preset value
// - Preset value selectable, reset by default
// - Unconnected gate counts as high
`timescale 1ns/1ps
module iirp_top (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_reset,
	// Avalon-MM slave
	input wire logic [iirp_pkg::ADDR_W-1:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [iirp_pkg::DATA_W-1:0] i_avs_writedata,
	input wire logic [3:0] i_avs_byteenable,
	output logic [iirp_pkg::DATA_W-1:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	// Pin and element controls
	input wire logic i_pin,
	input wire logic i_elem_clk,
	input wire logic i_global_set_reset,
	input wire logic i_logic_block_clock_gate,
	input wire logic i_clock_gate_connected,
	// Array side
	output logic o_array_input_path_a,
	output logic o_array_input_path_b,
	output logic o_output_gate_enable
);
	iirp_pkg::iirp_top_type st_ff; // Registered state
	iirp_pkg::iirp_top_type nxt_st; // Next state
	logic gate_eff; // Gate after connection default
	logic in_enable; // Enable seen by the input element
	logic stored_q; // Input element output
	logic req; // Bus request present
	logic accept; // Request completes this edge

	// Address match, shared by read and write decode
	function automatic logic reg_hit(input logic [iirp_pkg::ADDR_W-1:0] addr,
		input logic [iirp_pkg::ADDR_W-1:0] ofs);
		reg_hit = (addr == ofs);
	endfunction : reg_hit

	// Gate taken as is, no inversion; open input reads high
	assign gate_eff = i_clock_gate_connected ? i_logic_block_clock_gate : 1'b1;
	// Gate reaches the input element only when routed there
	assign in_enable = st_ff.ctrl[iirp_pkg::CTRL_GATE_IN] ? gate_eff : 1'b1;
	assign req = i_avs_read | i_avs_write;
	assign accept = req & ~st_ff.wait_n_ack;

	// Input storage element
	iirp_store u_store (
		.i_clk(i_clk),
		.i_reset(i_reset),
		.i_latch_mode(st_ff.ctrl[iirp_pkg::CTRL_LATCH]),
		.i_invert_clk(st_ff.ctrl[iirp_pkg::CTRL_INV_CLK]),
		.i_preset(st_ff.ctrl[iirp_pkg::CTRL_PRESET]),
		.i_gsr(i_global_set_reset),
		.i_elem_clk(i_elem_clk),
		.i_enable(in_enable),
		.i_d(i_pin),
		.o_q(stored_q)
	);

	// Bus, control register and array path next state
	always_comb begin
		nxt_st = st_ff;
		// Waitrequest drops for one cycle per request
		nxt_st.wait_n_ack = 1'b1;
		if (req && st_ff.wait_n_ack) begin
			nxt_st.wait_n_ack = 1'b0;
			nxt_st.rdata = iirp_pkg::UNMAPPED_DATA;
			if (reg_hit(i_avs_address, iirp_pkg::CTRL_OFS)) begin
				nxt_st.rdata[iirp_pkg::CTRL_W-1:0] = st_ff.ctrl;
			end else if (reg_hit(i_avs_address, iirp_pkg::STAT_OFS)) begin
				nxt_st.rdata[iirp_pkg::STAT_Q] = stored_q;
				nxt_st.rdata[iirp_pkg::STAT_PIN] = i_pin;
				nxt_st.rdata[iirp_pkg::STAT_GATE] = gate_eff;
			end
		end
		// Write lands at the edge that completes it
		if (accept && i_avs_write && i_avs_byteenable[0] && reg_hit(i_avs_address, iirp_pkg::CTRL_OFS)) begin
			nxt_st.ctrl = i_avs_writedata[iirp_pkg::CTRL_W-1:0];
		end
		// Each path picks direct pin or stored value
		nxt_st.path_a = st_ff.ctrl[iirp_pkg::CTRL_SEL_A] ? stored_q : i_pin;
		nxt_st.path_b = st_ff.ctrl[iirp_pkg::CTRL_SEL_B] ? stored_q : i_pin;
		// Same gate routed to the output element
		nxt_st.out_gate = st_ff.ctrl[iirp_pkg::CTRL_GATE_OUT] ? gate_eff : 1'b1;
		if (i_reset) begin
			// Defined state after reset
			nxt_st.ctrl = iirp_pkg::CTRL_RESET;
			nxt_st.wait_n_ack = 1'b1;
			nxt_st.rdata = iirp_pkg::UNMAPPED_DATA;
			nxt_st.path_a = 1'b0;
			nxt_st.path_b = 1'b0;
			nxt_st.out_gate = 1'b1;
		end
	end

	// State register
	always_ff @(posedge i_clk) begin
		st_ff <= nxt_st;
	end

	// Outputs straight from flip-flops
	assign o_avs_readdata = st_ff.rdata;
	assign o_avs_waitrequest = st_ff.wait_n_ack;
	assign o_array_input_path_a = st_ff.path_a;
	assign o_array_input_path_b = st_ff.path_b;
	assign o_output_gate_enable = st_ff.out_gate;

	// Request waiting for its answer
	sequence bus_pending_s;
		(i_avs_read || i_avs_write) && o_avs_waitrequest;
	endsequence
	// Answer followed by release of waitrequest
	sequence bus_answer_s;
		!o_avs_waitrequest ##1 o_avs_waitrequest;
	endsequence

	// Bus answers one cycle after a request
	bus_answer_a: assert property (@(posedge i_clk) disable iff (i_reset)
		bus_pending_s |=> bus_answer_s) else $error("waitrequest not answered in one cycle");
	// Control write is stored
	ctrl_write_a: assert property (@(posedge i_clk) disable iff (i_reset)
		(i_avs_write && !o_avs_waitrequest && i_avs_byteenable[0] && i_avs_address == iirp_pkg::CTRL_OFS)
		|=> (st_ff.ctrl == $past(i_avs_writedata[iirp_pkg::CTRL_W-1:0]))) else $error("control write lost");
	// First path follows its selection
	path_a_sel_a: assert property (@(posedge i_clk) disable iff (i_reset)
		1'b1 |=> (o_array_input_path_a == ($past(st_ff.ctrl[iirp_pkg::CTRL_SEL_A]) ? $past(stored_q) : $past(i_pin))))
		else $error("path a wrong source");
	// Second path follows its selection
	path_b_sel_a: assert property (@(posedge i_clk) disable iff (i_reset)
		1'b1 |=> (o_array_input_path_b == ($past(st_ff.ctrl[iirp_pkg::CTRL_SEL_B]) ? $past(stored_q) : $past(i_pin))))
		else $error("path b wrong source");
	// Output gate routing and polarity
	gate_route_a: assert property (@(posedge i_clk) disable iff (i_reset)
		1'b1 |=> (o_output_gate_enable == (!$past(st_ff.ctrl[iirp_pkg::CTRL_GATE_OUT])
		|| !$past(i_clock_gate_connected) || $past(i_logic_block_clock_gate)))) else $error("output gate misrouted");
endmodule : iirp_top

// file: verification/iirp_pin_model.sv
// Off-chip driver of the package pin and of the element clock.
// Assumes commands come from the bench and change just after a rising edge.
`timescale 1ns/1ps
module iirp_pin_model (
	// Clock
	input wire logic i_clk,
	// Commands from the bench
	input wire logic i_pin_cmd,
	input wire logic i_eclk_cmd,
	// Pin side levels
	output logic o_pin,
	output logic o_elem_clk
);
	// Board driver launches both levels one cycle after the command
	always @(posedge i_clk) begin
		o_pin <= i_pin_cmd;
		o_elem_clk <= i_eclk_cmd;
	end
endmodule : iirp_pin_model

// file: verification/tb_io_input_register_path.sv
// Bench for the pin input register path: bus tasks, pin stepping, checks.
// Assumes the design answers each bus request within a few cycles.
`timescale 1ns/1ps
module tb_io_input_register_path;
	logic i_clk = 1'b0, i_reset = 1'b1; // Clock, reset
	logic [3:0] adr = 4'h0, be = 4'hF; // Bus address, lanes
	logic rd = 1'b0, wr = 1'b0; // Bus strobes
	logic [31:0] wd = 32'h0, rdat, rv; // Bus data, driven read data, captured read data
	logic wreq; // Waitrequest from the design
	logic pin_c = 1'b0, eclk_c = 1'b0, pin, eclk; // Pin commands and levels
	logic global_set_reset = 1'b0, gate = 1'b1, conn = 1'b1; // Element controls
	logic pa, pb, og; // Array side
	int error_cnt = 0, num_checks = 0;
	// Clock at 100 MHz
	initial begin
		forever #5 i_clk = ~i_clk;
	end
	iirp_pin_model PM (.i_clk(i_clk), .i_pin_cmd(pin_c), .i_eclk_cmd(eclk_c), .o_pin(pin), .o_elem_clk(eclk));
	iirp_top DUT (.i_clk(i_clk), .i_reset(i_reset), .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr),
		.i_avs_writedata(wd), .i_avs_byteenable(be), .o_avs_readdata(rdat), .o_avs_waitrequest(wreq),
		.i_pin(pin), .i_elem_clk(eclk), .i_global_set_reset(global_set_reset), .i_logic_block_clock_gate(gate),
		.i_clock_gate_connected(conn), .o_array_input_path_a(pa), .o_array_input_path_b(pb),
		.o_output_gate_enable(og));
	// Compare and count
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	// One bus cycle, held until waitrequest is sampled low
	task bus(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
		int n;
		n = 0;
		rd <= !w;
		wr <= w;
		adr <= a;
		wd <= d;
		do begin
			@(posedge i_clk);
			n++;
		end while (wreq !== 1'b0 && n < 20);
		if (n >= 20) chk("waitrequest", 32'h0, 32'h1);
		r = rdat;
		rd <= 1'b0;
		wr <= 1'b0;
		@(posedge i_clk);
	endtask : bus
	// Drive pin and element clock, let them settle, check first path
	task step(input logic p, input logic c, input logic ea);
		pin_c <= p;
		eclk_c <= c;
		repeat (5) @(posedge i_clk);
		chk("path_a", {31'h0, ea}, {31'h0, pa});
	endtask : step
	// Closing verdict
	task final_report;
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : final_report
	// Watchdog
	initial begin
		repeat (5000) @(posedge i_clk);
		error_cnt++;
		final_report();
	end
	// Main sequence
	initial begin
		repeat (6) @(posedge i_clk);
		i_reset <= 1'b0;
		@(posedge i_clk);
		bus(1'b0, 4'h0, 32'h0, rv); chk("ctrl", 32'h30, rv);
		bus(1'b1, 4'h8, 32'h7F, rv);
		bus(1'b0, 4'h8, 32'h0, rv); chk("unmapped", 32'h0, rv);
		step(1'b1, 1'b0, 1'b1); chk("path_b", 32'h1, {31'h0, pb});
		bus(1'b1, 4'h0, 32'h31, rv);
		step(1'b1, 1'b0, 1'b0); chk("path_b", 32'h1, {31'h0, pb});
		step(1'b1, 1'b1, 1'b1);
		step(1'b0, 1'b1, 1'b1);
		step(1'b0, 1'b0, 1'b1);
		bus(1'b1, 4'h0, 32'h39, rv);
		step(1'b1, 1'b1, 1'b0);
		step(1'b1, 1'b0, 1'b1);
		bus(1'b1, 4'h0, 32'h35, rv);
		step(1'b0, 1'b1, 1'b0);
		step(1'b1, 1'b1, 1'b1);
		step(1'b0, 1'b0, 1'b1);
		gate <= 1'b0;
		step(1'b0, 1'b1, 1'b1); chk("out_gate", 32'h0, {31'h0, og});
		bus(1'b1, 4'h0, 32'h15, rv);
		step(1'b0, 1'b1, 1'b1); chk("out_gate", 32'h1, {31'h0, og});
		conn <= 1'b0;
		step(1'b0, 1'b1, 1'b0);
		conn <= 1'b1;
		gate <= 1'b1;
		bus(1'b1, 4'h0, 32'h75, rv);
		global_set_reset <= 1'b1;
		step(1'b0, 1'b1, 1'b1);
		global_set_reset <= 1'b0;
		eclk_c <= 1'b0;
		bus(1'b0, 4'h4, 32'h0, rv); chk("stat", 32'h5, rv);
		be <= 4'h0;
		bus(1'b1, 4'h0, 32'h30, rv);
		be <= 4'hF;
		bus(1'b0, 4'h0, 32'h0, rv); chk("ctrl_lanes", 32'h75, rv);
		final_report();
	end
endmodule : tb_io_input_register_path
